// file: core/ubd_dma_req.sv
// dma request and acknowledge logic for the first bulk endpoint
`timescale 1ns/1ps
module ubd_dma_req #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_soft_rst,
  // register port
  input wire logic i_reg_wr,
  input wire logic [1:0] i_reg_idx,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // endpoint side
  input wire logic i_dir_in,
  input wire logic [1:0] i_ep_num,
  input wire logic [6:0] i_max_pkt,
  input wire logic i_rx_pkt_good,
  input wire logic [6:0] i_rx_byte_cnt,
  input wire ubd_pkg::ubd_byte_type i_rx_byte,
  output logic o_rx_ready,
  input wire logic i_tx_prep,
  input wire logic i_tx_acked,
  input wire logic i_tx_rdy_set,
  output ubd_pkg::ubd_byte_type o_tx_byte,
  input wire logic i_tx_ready,
  output logic o_rx_pkt_rdy,
  output logic o_tx_pkt_rdy,
  // dma pins
  output logic o_dma_request_pin,
  input wire logic i_dma_acknowledge_pin,
  input wire logic i_dma_cs,
  input wire logic i_dma_rd,
  input wire logic i_dma_wr,
  input wire logic [15:0] i_dma_data,
  output logic [15:0] o_dma_data,
  output logic o_dma_data_oe
);
  import ubd_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_RD_HI, ST_WR_HI} ubd_mv_type;

  ubd_pol_type pol_r;
  ubd_ctl_type ctl_r;
  logic [7:0] intvl_r;
  ubd_mv_type st_r;
  logic rx_rdy_r;
  logic tx_rdy_r;
  logic hdr_pend_r;
  logic [6:0] cnt_r;
  logic [6:0] rem_r;
  logic [6:0] tx_cnt_r;
  logic [7:0] hi_byte_r;
  logic [GAP_W-1:0] gap_r;
  logic dma_request_pin_act_r;
  logic dma_request_pin_act_nxt;
  logic rd_d_r;
  logic wr_d_r;
  logic [19:0] pins_s;
  logic dma_acknowledge_pin_s;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic [15:0] wd_s;
  logic clr;
  logic ep_ok;
  logic sel;
  logic rd_acc;
  logic wr_acc;
  logic acc_done;
  logic rx_cond;
  logic tx_cond;
  logic f_in_valid;
  logic [7:0] f_in_data;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_out_data;
  logic f_pop;
  logic [CW-1:0] f_cnt;
  logic rx_pop;
  logic tx_push;
  logic [7:0] tx_push_data;
  logic tx_full_pkt;

  function automatic logic [GAP_W-1:0] gap_cycles(input logic [7:0] n);
    gap_cycles = GAP_W'(REQ_EN_CYC) + GAP_W'(n) * GAP_W'(BIT_CYC);
  endfunction

  assign clr = !i_rst_b || i_soft_rst;
  assign ep_ok = (i_ep_num == FIRST_BULK_EP);

  // ==========================================================
  // pin synchronisers
  ubd_sync #(.WIDTH(20)) u_sync (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .i_async({i_dma_acknowledge_pin, i_dma_cs, i_dma_rd, i_dma_wr,
              i_dma_data}),
    .o_sync(pins_s)
  );
  assign {dma_acknowledge_pin_s, cs_s, rd_s, wr_s, wd_s} = pins_s;

  // address mode select
  // single mode uses acknowledge, dual mode uses chip select instead
  assign sel = ctl_r.dual ? cs_s : (dma_acknowledge_pin_s ^ pol_r.dma_acknowledge_pin_low);
  assign rd_acc = sel && rd_s && !rd_d_r && !i_dir_in && st_r == ST_IDLE;
  assign wr_acc = sel && wr_s && !wr_d_r && i_dir_in && st_r == ST_IDLE;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
    end else if (i_ce) begin
      rd_d_r <= rd_s;
      wr_d_r <= wr_s;
    end
  end

  // ==========================================================
  // registers
  // reset polarities
  always_ff @(posedge i_mclk) begin
    if (clr) begin
      pol_r <= POL_RST;
      ctl_r <= CTL_RST;
      intvl_r <= INTVL_RST;
    end else if (i_ce && i_reg_wr) begin
      case (i_reg_idx)
        REG_PIN_POLARITY_SELECT_IDX: pol_r <= ubd_pol_type'({5'h00, i_reg_wdata[2:0]});
        REG_DMACTL_IDX: ctl_r <= ubd_ctl_type'(i_reg_wdata & 8'h9F);
        REG_INTVL_IDX: intvl_r <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (clr) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      case (i_reg_idx)
        REG_PIN_POLARITY_SELECT_IDX: o_reg_rdata <= pol_r;
        REG_DMACTL_IDX: o_reg_rdata <= ctl_r;
        REG_INTVL_IDX: o_reg_rdata <= intvl_r;
        default: o_reg_rdata <= {5'h00, dma_request_pin_act_r, tx_rdy_r, rx_rdy_r};
      endcase
    end
  end

  // ==========================================================
  // staging fifo, direction chosen by endpoint configuration
  assign f_in_valid = i_dir_in ? tx_push : i_rx_byte.valid;
  assign f_in_data = i_dir_in ? tx_push_data : i_rx_byte.data;
  assign f_pop = i_dir_in ? i_tx_ready : rx_pop;
  assign o_rx_ready = !i_dir_in && f_in_ready;
  assign o_tx_byte.valid = i_dir_in && f_out_valid;
  assign o_tx_byte.data = f_out_data;

  ubd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b && !i_soft_rst),
    .i_ce(i_ce),
    .i_in_valid(f_in_valid),
    .i_in_data(f_in_data),
    .o_in_ready(f_in_ready),
    .o_out_valid(f_out_valid),
    .o_out_data(f_out_data),
    .i_out_ready(f_pop),
    .o_count(f_cnt)
  );

  // ==========================================================
  // byte mover
  // width select drives the two-phase word path
  assign rx_pop = (rd_acc && !hdr_pend_r) ||
                  (st_r == ST_RD_HI && f_out_valid);
  assign tx_push = wr_acc || st_r == ST_WR_HI;
  assign tx_push_data = wr_acc ? wd_s[7:0] : hi_byte_r;
  assign acc_done = (rd_acc && (hdr_pend_r || !ctl_r.width16 ||
                    rem_r == 7'h01)) ||
                    (wr_acc && !ctl_r.width16) ||
                    (st_r == ST_RD_HI && f_out_valid) ||
                    st_r == ST_WR_HI;

  always_ff @(posedge i_mclk) begin
    if (clr) begin
      st_r <= ST_IDLE;
    end else if (i_ce) begin
      case (st_r)
        ST_IDLE: begin
          if (rd_acc && !hdr_pend_r && ctl_r.width16 && rem_r != 7'h01)
            st_r <= ST_RD_HI;
          else if (wr_acc && ctl_r.width16)
            st_r <= ST_WR_HI;
        end
        ST_RD_HI: if (f_out_valid) st_r <= ST_IDLE;
        ST_WR_HI: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (clr) begin
      o_dma_data <= 16'h0000;
      hi_byte_r <= 8'h00;
    end else if (i_ce) begin
      if (wr_acc) hi_byte_r <= wd_s[15:8];
      if (rd_acc && hdr_pend_r) begin
        o_dma_data <= {8'h00, 1'b0, cnt_r};
      end else if (rd_acc) begin
        o_dma_data <= {8'h00, f_out_data};
      end else if (st_r == ST_RD_HI && f_out_valid) begin
        o_dma_data[15:8] <= f_out_data;
      end
    end
  end

  assign o_dma_data_oe = sel && rd_s && !i_dir_in;

  // ==========================================================
  // receive packet state
  always_ff @(posedge i_mclk) begin
    if (clr) begin
      rx_rdy_r <= 1'b0;
      hdr_pend_r <= 1'b0;
      cnt_r <= 7'h00;
      rem_r <= 7'h00;
    end else if (i_ce) begin
      if (rd_acc && hdr_pend_r) hdr_pend_r <= 1'b0;
      if (rx_pop) rem_r <= rem_r - 7'h01;
      if (rx_rdy_r && rem_r == 7'h00 && !hdr_pend_r && st_r == ST_IDLE)
        rx_rdy_r <= 1'b0;
      // good packet sets ready; set wins over clear
      if (i_rx_pkt_good && ep_ok && !i_dir_in) begin
        rx_rdy_r <= 1'b1;
        cnt_r <= i_rx_byte_cnt;
        rem_r <= i_rx_byte_cnt;
        hdr_pend_r <= ctl_r.cnt_ins;
      end
    end
  end

  // ==========================================================
  // transmit packet state
  assign tx_full_pkt = tx_push && (tx_cnt_r + 7'h01 >= i_max_pkt);

  always_ff @(posedge i_mclk) begin
    if (clr) begin
      tx_rdy_r <= 1'b0;
      tx_cnt_r <= 7'h00;
    end else if (i_ce) begin
      if (tx_push) tx_cnt_r <= tx_cnt_r + 7'h01;
      if (i_tx_acked && ep_ok && i_dir_in) tx_rdy_r <= 1'b0;
      // full packet sets ready, software sets short one
      if (tx_full_pkt || i_tx_rdy_set) begin
        tx_rdy_r <= 1'b1;
        tx_cnt_r <= 7'h00;
      end
    end
  end

  assign o_rx_pkt_rdy = rx_rdy_r;
  assign o_tx_pkt_rdy = tx_rdy_r;

  // ==========================================================
  // request conditions
  // a 16-bit read waits for two staged bytes unless only one is left
  assign rx_cond = rx_rdy_r && (hdr_pend_r ||
                   (rem_r != 7'h00 && f_cnt >= ((ctl_r.width16 &&
                   rem_r != 7'h01) ? CW'(2) : CW'(1))));
  // transmit request while fifo has room and packet not ready
  assign tx_cond = i_tx_prep && !tx_rdy_r && !tx_full_pkt &&
                   (DEPTH_C - f_cnt) >= CW'(2);

  always_ff @(posedge i_mclk) begin
    if (clr) begin
      gap_r <= '0;
    end else if (i_ce) begin
      // gap of enable time plus n bit times
      if (acc_done && !ctl_r.demand) gap_r <= gap_cycles(intvl_r);
      else if (gap_r != '0) gap_r <= gap_r - 1'b1;
    end
  end

  // single drops per access, demand holds across accesses
  // demand still drops if the endpoint side starves the staging fifo
  always_comb begin
    dma_request_pin_act_nxt = ctl_r.enable && !ctl_r.pause &&
                   (i_dir_in ? tx_cond : rx_cond);
    if (!ctl_r.demand && (st_r != ST_IDLE || gap_r != '0 || rd_acc ||
        wr_acc || acc_done))
      dma_request_pin_act_nxt = 1'b0;
  end

  always_ff @(posedge i_mclk) begin
    if (clr) begin
      dma_request_pin_act_r <= 1'b0;
      o_dma_request_pin <= 1'b1;
    end else if (i_ce) begin
      dma_request_pin_act_r <= dma_request_pin_act_nxt;
      o_dma_request_pin <= dma_request_pin_act_nxt ~^ pol_r.dma_request_pin_high;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b || !i_ce);

  a_enable_gate: assert property (
    !ctl_r.enable |=> !dma_request_pin_act_r
  ) else $error("request active while dma disabled");

  a_pause_drop: assert property (
    ctl_r.pause ##1 ctl_r.pause |-> !dma_request_pin_act_r
  ) else $error("request active during pause");

  a_pin_polarity: assert property (
    !$past(clr) |->
      o_dma_request_pin == (dma_request_pin_act_r ~^ $past(pol_r.dma_request_pin_high))
  ) else $error("request pin polarity wrong");

  a_reset_defaults: assert property (
    disable iff (1'b0) (!i_rst_b || i_soft_rst) && i_ce |=>
      pol_r == POL_RST && o_dma_request_pin
  ) else $error("reset polarity not restored");

  a_rx_set: assert property (
    i_rx_pkt_good && ep_ok && !i_dir_in && !i_soft_rst |=> rx_rdy_r
  ) else $error("receive ready not set");

  a_rx_other_ep: assert property (
    !rx_rdy_r && !i_dir_in && !(i_rx_pkt_good && ep_ok) |=> !rx_rdy_r
  ) else $error("receive ready set for another endpoint");

  a_tx_hold: assert property (
    i_dir_in && tx_rdy_r |=> !dma_request_pin_act_r
  ) else $error("transmit request while packet ready");

  a_tx_auto: assert property (
    tx_full_pkt && !i_soft_rst |=> tx_rdy_r && tx_cnt_r == 7'h00
  ) else $error("full packet did not set transmit ready");

  a_gap_load: assert property (
    acc_done && !ctl_r.demand && !i_soft_rst |=>
      gap_r == gap_cycles($past(intvl_r))
  ) else $error("interval not loaded");

  a_gap_quiet: assert property (
    gap_r != '0 && !ctl_r.demand |=> !dma_request_pin_act_r
  ) else $error("request during interval");

  a_hdr_word: assert property (
    rd_acc && hdr_pend_r && !i_soft_rst |=>
      o_dma_data == {9'h000, $past(cnt_r)}
  ) else $error("count word malformed");

  a_odd_pad: assert property (
    rd_acc && !hdr_pend_r && ctl_r.width16 && rem_r == 7'h01 &&
    !i_soft_rst |=> o_dma_data[15:8] == 8'h00 && st_r == ST_IDLE
  ) else $error("odd tail not padded");

  c_rx_word: cover property (st_r == ST_RD_HI ##1 st_r == ST_IDLE);
  c_tx_word: cover property (st_r == ST_WR_HI);
  c_hdr_read: cover property (rd_acc && hdr_pend_r);
  c_gap_run: cover property (gap_r != '0 ##1 gap_r == '0);
endmodule

// file: core/ubd_fifo.sv
// byte staging fifo with valid and ready on both sides
`timescale 1ns/1ps
module ubd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic push;
  logic pop;

  assign o_in_ready = (o_count != FULL);
  assign o_out_valid = (o_count != '0);
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ==========================================================
  // pointers and occupancy
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      o_count <= '0;
    end else if (i_ce) begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      if (push && !pop) o_count <= o_count + 1'b1;
      else if (pop && !push) o_count <= o_count - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ce && push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end
endmodule

// file: core/ubd_pkg.sv
// shared constants and types for the bulk endpoint dma request block
package ubd_pkg;

  // ==========================================================
  // register indexes
  localparam logic [1:0] REG_PIN_POLARITY_SELECT_IDX = 2'h0;
  localparam logic [1:0] REG_DMACTL_IDX = 2'h1;
  localparam logic [1:0] REG_INTVL_IDX = 2'h2;
  localparam logic [1:0] REG_STATUS_IDX = 2'h3;

  // ==========================================================
  // field layouts
  typedef struct packed {
    logic [4:0] rsvd;
    logic dma_acknowledge_pin_low;
    logic dma_request_pin_high;
    logic intr_high;
  } ubd_pol_type;

  typedef struct packed {
    logic pause;
    logic [1:0] rsvd;
    logic demand;
    logic width16;
    logic cnt_ins;
    logic dual;
    logic enable;
  } ubd_ctl_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } ubd_byte_type;

  localparam ubd_pol_type POL_RST = '0;
  localparam ubd_ctl_type CTL_RST = '0;
  localparam logic [7:0] INTVL_RST = 8'h00;
  localparam logic [1:0] FIRST_BULK_EP = 2'h1;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS = 84;
  localparam int REQ_EN_TIME_NS = 50;
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ_EN_CYC =
    (REQ_EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 12;

endpackage

// file: core/ubd_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ubd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  // ==========================================================
  // no reset: pins carry no state worth clearing
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// file: dv/ubd_dma_req_tb.sv
// self-checking bench for the bulk endpoint dma request block
`timescale 1ns/1ps
module ubd_dma_req_tb;
  import ubd_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic i_soft_rst = 1'b0;
  logic i_reg_wr = 1'b0;
  logic [1:0] i_reg_idx = 2'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_dir_in = 1'b0;
  logic [1:0] i_ep_num = 2'h0;
  logic [6:0] i_max_pkt = 7'h04;
  logic i_rx_pkt_good = 1'b0;
  logic [6:0] i_rx_byte_cnt = 7'h00;
  ubd_byte_type i_rx_byte = '0;
  logic i_tx_prep = 1'b0;
  logic i_tx_acked = 1'b0;
  logic i_tx_rdy_set = 1'b0;
  logic i_tx_ready = 1'b0;
  logic [7:0] o_reg_rdata;
  ubd_byte_type o_tx_byte;
  logic o_rx_ready, o_rx_pkt_rdy, o_tx_pkt_rdy, o_dma_request_pin;
  logic o_dma_data_oe, ack, cs, rd, wr;
  logic [15:0] o_dma_data, wdata;
  logic req_high = 1'b0;
  logic ack_low = 1'b0;
  logic dual = 1'b0;
  logic go = 1'b0;
  int mismatches = 0;
  int num_checks = 0;

  // ==========================================================
  // clock, design and far side
  initial forever #12.5 i_mclk = ~i_mclk;

  ubd_dma_req #(.FIFO_DEPTH(8)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_ce(i_ce), .i_soft_rst(i_soft_rst), .i_reg_wr(i_reg_wr),
    .i_reg_idx(i_reg_idx), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_dir_in(i_dir_in), .i_ep_num(i_ep_num),
    .i_max_pkt(i_max_pkt), .i_rx_pkt_good(i_rx_pkt_good),
    .i_rx_byte_cnt(i_rx_byte_cnt), .i_rx_byte(i_rx_byte),
    .o_rx_ready(o_rx_ready), .i_tx_prep(i_tx_prep),
    .i_tx_acked(i_tx_acked), .i_tx_rdy_set(i_tx_rdy_set),
    .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready),
    .o_rx_pkt_rdy(o_rx_pkt_rdy), .o_tx_pkt_rdy(o_tx_pkt_rdy),
    .o_dma_request_pin(o_dma_request_pin), .i_dma_acknowledge_pin(ack),
    .i_dma_cs(cs), .i_dma_rd(rd), .i_dma_wr(wr), .i_dma_data(wdata),
    .o_dma_data(o_dma_data), .o_dma_data_oe(o_dma_data_oe));

  ubd_dmac_model dmac (.i_mclk(i_mclk), .i_req_pin(o_dma_request_pin),
    .i_req_high(req_high), .i_ack_low(ack_low), .i_dual(dual),
    .i_write(i_dir_in), .i_go(go), .i_rdata(o_dma_data), .o_ack(ack),
    .o_cs(cs), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_req(input logic act);
    chk(16'(o_dma_request_pin), 16'(act ? req_high : !req_high));
  endtask

  task automatic wr_reg(input logic [1:0] idx, input logic [7:0] v);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_idx <= idx;
    i_reg_wdata <= v;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [1:0] idx, input logic [7:0] exp);
    @(posedge i_mclk);
    i_reg_idx <= idx;
    repeat (2) @(posedge i_mclk);
    #1 chk(16'(o_reg_rdata), 16'(exp));
  endtask

  task automatic rx_pkt(input logic [1:0] ep, input logic [6:0] n);
    @(posedge i_mclk);
    i_ep_num <= ep;
    i_rx_pkt_good <= 1'b1;
    i_rx_byte_cnt <= n;
    @(posedge i_mclk);
    i_rx_pkt_good <= 1'b0;
  endtask

  task automatic push3(input logic [7:0] a, b, c);
    logic [7:0] q[3];
    int k, w;
    q = '{a, b, c};
    @(posedge i_mclk);
    for (k = 0; k < 3; k++) begin
      i_rx_byte <= {q[k], 1'b1};
      for (w = 0; w < 50; w++) begin
        #1;
        if (o_rx_ready === 1'b1) break;
        @(posedge i_mclk);
      end
      @(posedge i_mclk);
    end
    i_rx_byte <= '0;
  endtask

  // bounded wait: a stuck request shows up as a short count
  task automatic run_dma(input int n);
    int target, k;
    target = dmac.n_done + n;
    dmac.rd_q.delete();
    dmac.req_q.delete();
    @(posedge i_mclk);
    go <= 1'b1;
    for (k = 0; k < 600 && dmac.n_done < target; k++) @(posedge i_mclk);
    go <= 1'b0;
    chk(16'(dmac.n_done), 16'(target));
  endtask

  // ==========================================================
  // scenarios
  task automatic s_reset_regs();
    #1 chk(16'(o_dma_request_pin), 16'h0001);
    rd_chk(REG_PIN_POLARITY_SELECT_IDX, 8'h00);
    rd_chk(REG_DMACTL_IDX, 8'h00);
    wr_reg(REG_DMACTL_IDX, 8'h64);
    rd_chk(REG_DMACTL_IDX, 8'h04);
    wr_reg(REG_INTVL_IDX, 8'h02);
    rd_chk(REG_INTVL_IDX, 8'h02);
    // a write while the clock enable is low must not land
    @(posedge i_mclk);
    i_ce <= 1'b0;
    wr_reg(REG_INTVL_IDX, 8'h07);
    i_ce <= 1'b1;
    rd_chk(REG_INTVL_IDX, 8'h02);
  endtask

  task automatic s_rx8();
    logic [7:0] e[4];
    int k;
    e = '{8'h03, 8'h11, 8'h22, 8'h33};
    rx_pkt(FIRST_BULK_EP, 7'd3);
    push3(8'h11, 8'h22, 8'h33);
    repeat (8) @(posedge i_mclk);
    #1 chk(16'(o_rx_pkt_rdy), 16'h0001);
    chk(16'(o_rx_ready), 16'h0001);
    chk_req(1'b0);
    wr_reg(REG_DMACTL_IDX, 8'h05);
    run_dma(4);
    for (k = 0; k < 4; k++) begin
      chk(16'(dmac.rd_q[k][7:0]), 16'(e[k]));
      chk(16'(dmac.req_q[k]), 16'h0000);
    end
    repeat (8) @(posedge i_mclk);
    #1 chk(16'(o_rx_pkt_rdy), 16'h0000);
    chk_req(1'b0);
    chk(16'(o_dma_data_oe), 16'h0000);
  endtask

  task automatic s_rx16();
    wr_reg(REG_PIN_POLARITY_SELECT_IDX, 8'h06);
    req_high <= 1'b1;
    ack_low <= 1'b1;
    wr_reg(REG_DMACTL_IDX, 8'h1D);
    rx_pkt(2'h2, 7'd3);
    repeat (8) @(posedge i_mclk);
    #1 chk(16'(o_dma_request_pin), 16'h0000);
    chk_req(1'b0);
    rx_pkt(FIRST_BULK_EP, 7'd3);
    push3(8'hA1, 8'hB2, 8'hC3);
    run_dma(3);
    chk(dmac.rd_q[0], 16'h0003);
    chk(dmac.rd_q[1], 16'hB2A1);
    chk(dmac.rd_q[2], 16'h00C3);
    chk(16'(dmac.req_q[0] & dmac.req_q[1]), 16'h0001);
  endtask

  task automatic s_tx();
    int k;
    @(posedge i_mclk);
    i_soft_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_soft_rst <= 1'b0;
    req_high <= 1'b0;
    ack_low <= 1'b0;
    #1 chk(16'(o_dma_request_pin), 16'h0001);
    rd_chk(REG_PIN_POLARITY_SELECT_IDX, 8'h00);
    wr_reg(REG_DMACTL_IDX, 8'h03);
    i_dir_in <= 1'b1;
    i_tx_prep <= 1'b1;
    dual <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1 chk_req(1'b1);
    run_dma(2);
    wr_reg(REG_DMACTL_IDX, 8'h83);
    repeat (6) @(posedge i_mclk);
    #1 chk_req(1'b0);
    wr_reg(REG_DMACTL_IDX, 8'h03);
    repeat (6) @(posedge i_mclk);
    #1 chk_req(1'b1);
    run_dma(2);
    repeat (8) @(posedge i_mclk);
    #1 chk(16'(o_tx_pkt_rdy), 16'h0001);
    chk_req(1'b0);
    @(posedge i_mclk);
    i_tx_ready <= 1'b1;
    for (k = 0; k < 4; k++) begin
      #1 chk(16'(o_tx_byte.data), 16'h0050 + 16'(k));
      @(posedge i_mclk);
    end
    i_tx_ready <= 1'b0;
    #1 chk(16'(o_tx_byte.valid), 16'h0000);
    @(posedge i_mclk);
    i_ep_num <= FIRST_BULK_EP;
    i_tx_acked <= 1'b1;
    @(posedge i_mclk);
    i_tx_acked <= 1'b0;
    repeat (6) @(posedge i_mclk);
    #1 chk(16'(o_tx_pkt_rdy), 16'h0000);
    chk_req(1'b1);
    rd_chk(REG_STATUS_IDX, 8'h04);
    // short last packet: software marks it ready itself
    @(posedge i_mclk);
    i_tx_rdy_set <= 1'b1;
    @(posedge i_mclk);
    i_tx_rdy_set <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 chk(16'(o_tx_pkt_rdy), 16'h0001);
    chk_req(1'b0);
  endtask

  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    s_reset_regs();
    s_rx8();
    s_rx16();
    s_tx();
    report_and_stop();
  end
endmodule

// file: dv/ubd_dmac_model.sv
// behavioural dma controller on the far side of the request pins
`timescale 1ns/1ps
module ubd_dmac_model (
  input wire logic i_mclk,
  input wire logic i_req_pin,
  input wire logic i_req_high,
  input wire logic i_ack_low,
  input wire logic i_dual,
  input wire logic i_write,
  input wire logic i_go,
  input wire logic [15:0] i_rdata,
  output logic o_ack,
  output logic o_cs,
  output logic o_rd,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  int n_done = 0;
  logic [15:0] rd_q[$];
  logic req_q[$];
  logic [7:0] seq = 8'h50;
  logic ack_on = 1'b0;

  // ==========================================================
  // acknowledge pin
  // polarity applied here so the pin idles inactive
  assign o_ack = i_ack_low ^ ack_on;

  // ==========================================================
  // access engine
  initial begin
    {o_cs, o_rd, o_wr} = 3'b000;
    o_wdata = 16'h0000;
    forever begin
      @(posedge i_mclk);
      #1;
      if (i_go && i_req_pin === i_req_high) begin
        // fifo picked by acknowledge, or chip select in dual mode
        ack_on <= !i_dual;
        o_cs <= i_dual;
        o_rd <= !i_write;
        o_wr <= i_write;
        o_wdata <= {~seq, seq};
        // strobe held well past the two-stage pin synchroniser
        repeat (6) @(posedge i_mclk);
        #1;
        if (!i_write) rd_q.push_back(i_rdata);
        // request level seen as each access ends
        req_q.push_back(i_req_pin === i_req_high);
        n_done <= n_done + 1;
        if (i_write) seq <= seq + 8'h01;
        ack_on <= 1'b0;
        {o_cs, o_rd, o_wr} <= 3'b000;
        // released bus shows the inverse, never a stale value
        o_wdata <= ~o_wdata;
        repeat (3) @(posedge i_mclk);
      end
    end
  end
endmodule
